/* rtl/lpsl_defines.vh */
// Purpose: constants of the programmable logic slice
// Assumes: 10 MHz clk_i, classic Wishbone register access
// Notes: definitions only
//
// Operation
// - full unit selects logic, ripple, RAM or ROM; one mode at a time.
// - reduced unit offers logic, ripple and ROM, never RAM.
// - logic mode: each table gives any function of four inputs, 16 entries.
// - two tables muxed into one five-input function on the first wide output.
// - second wide output cascades neighbour results into six to eight inputs.
// - ripple mode: 2-bit add, subtract, dynamic add/subtract, up and down count.
// - ripple mode compares operands (ge, ne, le) and builds multipliers.
// - ripple mode produces carry generate and carry propagate.
// - carry enters on the chain input and leaves on the chain output.
// - RAM mode: each table is 16x1; slice forms single-port 16x2.
// - each table result given as bypass output and as registered output.
`ifndef LPSL_DEFINES_VH
`define LPSL_DEFINES_VH

// --------------------------------------------------------------
// register map
// --------------------------------------------------------------
`define LPSL_ADR_W 5
`define LPSL_ADR_CTRL 5'h00
`define LPSL_ADR_TABLE_A 5'h04
`define LPSL_ADR_TABLE_B 5'h08
`define LPSL_ADR_STATUS 5'h0c

// --------------------------------------------------------------
// control fields and reset values
// --------------------------------------------------------------
`define LPSL_CTRL_MODE_LSB 0
`define LPSL_CTRL_OP_LSB 2
`define LPSL_CTRL_INIT0_BIT 5
`define LPSL_CTRL_INIT1_BIT 6
`define LPSL_CTRL_RST 7'h00
`define LPSL_TABLE_RST 16'h0000
`define LPSL_TABLE_DEPTH 16
`define LPSL_TABLE_AW 4

// --------------------------------------------------------------
// modes and ripple operations
// --------------------------------------------------------------
`define LPSL_MODE_LOGIC 2'h0
`define LPSL_MODE_RIPPLE 2'h1
`define LPSL_MODE_RAM 2'h2
`define LPSL_MODE_ROM 2'h3
`define LPSL_OP_ADD 3'h0
`define LPSL_OP_SUB 3'h1
`define LPSL_OP_ADDSUB 3'h2
`define LPSL_OP_UP 3'h3
`define LPSL_OP_DOWN 3'h4
`define LPSL_OP_MULT 3'h5
`define LPSL_OP_CMP 3'h6

// --------------------------------------------------------------
// synchronised input vector
// --------------------------------------------------------------
`define LPSL_IN_W 15

`endif

/* rtl/lpsl_ripple.v */
// Purpose: 2-bit ripple arithmetic unit of the slice
// Assumes: purely combinational
// Notes: carry semantics, subtraction is a plus inverted b plus carry
`timescale 1ns/1ps
`include "lpsl_defines.vh"

module lpsl_ripple (
  input wire [2:0] op_i,
  input wire [1:0] a_i,
  input wire [1:0] b_i,
  input wire cin_i,
  input wire dyn_i,
  output reg [1:0] sum_o,
  output reg cout_o,
  output reg gen_o,
  output reg prop_o,
  output reg ge_o,
  output reg ne_o,
  output reg le_o
);

  reg [1:0] b_eff;
  reg c_eff;
  reg [2:0] total;
  reg [1:0] g;
  reg [1:0] p;

  always @* begin
    b_eff = b_i;
    c_eff = cin_i;
    case (op_i)
      `LPSL_OP_ADD: b_eff = b_i;
      `LPSL_OP_SUB: b_eff = ~b_i;
      `LPSL_OP_ADDSUB: b_eff = dyn_i ? ~b_i : b_i;
      `LPSL_OP_UP: b_eff = 2'h0;
      `LPSL_OP_DOWN: begin
        b_eff = {2{cin_i}};
        c_eff = 1'b0;
      end
      `LPSL_OP_MULT: b_eff = b_i & {2{dyn_i}};
      `LPSL_OP_CMP: b_eff = ~b_i;
      default: b_eff = b_i;
    endcase
    total = {1'b0, a_i} + {1'b0, b_eff} + {2'h0, c_eff};
    sum_o = total[1:0];
    g = a_i & b_eff;
    p = a_i ^ b_eff;
    gen_o = g[1] | (p[1] & g[0]);
    prop_o = p[1] & p[0];
    cout_o = total[2];
    ge_o = (a_i >= b_i);
    ne_o = (a_i != b_i);
    le_o = (a_i <= b_i);
  end

endmodule

/* rtl/lpsl_slice.v */
// Purpose: programmable logic slice with Wishbone configuration port
// Assumes: all fabric inputs arrive from outside the clock domain
// Notes: FULL_UNIT=0 builds the reduced unit without RAM mode
`timescale 1ns/1ps
`include "lpsl_defines.vh"

module lpsl_slice #(
  parameter FULL_UNIT = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`LPSL_ADR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire [3:0] table_a_inputs_i,
  input wire [3:0] table_b_inputs_i,
  input wire multipurpose_in_a_i,
  input wire multipurpose_in_b_i,
  input wire clk_en_i,
  input wire local_set_reset_i,
  input wire carry_chain_in_i,
  input wire wide_in_a_i,
  input wire wide_in_b_i,
  output reg [1:0] table_bypass_out_o,
  output reg [1:0] registered_out_o,
  output reg five_input_mux_out_o,
  output reg wide_mux_out_o,
  output reg carry_chain_out_o,
  output reg carry_gen_o,
  output reg carry_prop_o,
  output reg cmp_ge_o,
  output reg cmp_ne_o,
  output reg cmp_le_o
);

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  function mode_allowed;
    input [1:0] mode;
    begin
      mode_allowed = (mode != `LPSL_MODE_RAM) || (FULL_UNIT != 0);
    end
  endfunction

  function [15:0] merge_bytes;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] sel;
    begin
      merge_bytes[7:0] = sel[0] ? new_val[7:0] : old_val[7:0];
      merge_bytes[15:8] = sel[1] ? new_val[15:8] : old_val[15:8];
    end
  endfunction

  function mode_is;
    input [1:0] cur;
    input [1:0] want;
    begin
      mode_is = (cur == want);
    end
  endfunction

  function adr_is;
    input [`LPSL_ADR_W-1:0] adr;
    input [`LPSL_ADR_W-1:0] want;
    begin
      adr_is = (adr == want);
    end
  endfunction

  function counts;
    input [2:0] op;
    begin
      counts = (op == `LPSL_OP_UP) || (op == `LPSL_OP_DOWN);
    end
  endfunction

  // --------------------------------------------------------------
  // input synchroniser
  // --------------------------------------------------------------
  wire [`LPSL_IN_W-1:0] in_raw;
  reg [`LPSL_IN_W-1:0] sync1_q;
  reg [`LPSL_IN_W-1:0] sync2_q;

  assign in_raw = {table_a_inputs_i, table_b_inputs_i, multipurpose_in_a_i,
                   multipurpose_in_b_i, clk_en_i, local_set_reset_i,
                   carry_chain_in_i, wide_in_a_i, wide_in_b_i};

  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= {`LPSL_IN_W{1'b0}};
      sync2_q <= {`LPSL_IN_W{1'b0}};
    end else begin
      sync1_q <= in_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [3:0] ta_s = sync2_q[14:11];
  wire [3:0] tb_s = sync2_q[10:7];
  wire mpa_s = sync2_q[6];
  wire mpb_s = sync2_q[5];
  wire ce_s = sync2_q[4];
  wire lsr_s = sync2_q[3];
  wire cin_s = sync2_q[2];
  wire wa_s = sync2_q[1];
  wire wb_s = sync2_q[0];

  // --------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------
  reg [1:0] mode_q;
  reg [2:0] op_q;
  reg [1:0] init_q;
  wire [15:0] cont_a;
  wire [15:0] cont_b;
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr = wb_req & wb_we_i;
  wire hit_ctrl = adr_is(wb_adr_i, `LPSL_ADR_CTRL);
  wire hit_ta = adr_is(wb_adr_i, `LPSL_ADR_TABLE_A);
  wire hit_tb = adr_is(wb_adr_i, `LPSL_ADR_TABLE_B);
  wire hit_st = adr_is(wb_adr_i, `LPSL_ADR_STATUS);
  wire [1:0] new_mode = wb_dat_i[`LPSL_CTRL_MODE_LSB+1:`LPSL_CTRL_MODE_LSB];
  wire [2:0] new_op = wb_dat_i[`LPSL_CTRL_OP_LSB+2:`LPSL_CTRL_OP_LSB];
  wire [1:0] new_init = {wb_dat_i[`LPSL_CTRL_INIT1_BIT], wb_dat_i[`LPSL_CTRL_INIT0_BIT]};
  wire [6:0] ctrl_rst = `LPSL_CTRL_RST;

  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= ctrl_rst[`LPSL_CTRL_MODE_LSB+1:`LPSL_CTRL_MODE_LSB];
      op_q <= ctrl_rst[`LPSL_CTRL_OP_LSB+2:`LPSL_CTRL_OP_LSB];
      init_q <= {ctrl_rst[`LPSL_CTRL_INIT1_BIT], ctrl_rst[`LPSL_CTRL_INIT0_BIT]};
    end else if (wb_wr && hit_ctrl && wb_sel_i[0]) begin
      if (mode_allowed(new_mode)) begin
        mode_q <= new_mode;
      end
      op_q <= new_op;
      init_q <= new_init;
    end
  end

  // --------------------------------------------------------------
  // lookup tables
  // --------------------------------------------------------------
  wire ram_mode = mode_is(mode_q, `LPSL_MODE_RAM) && (FULL_UNIT != 0);
  wire [1:0] tab_load;
  wire [15:0] tab_load_dat [0:1];
  wire [3:0] tab_addr [0:1];
  wire [1:0] tab_wdat;
  wire [1:0] tab_rd;

  assign tab_load = {wb_wr & hit_tb, wb_wr & hit_ta};
  assign tab_load_dat[0] = merge_bytes(cont_a, wb_dat_i[15:0], wb_sel_i[1:0]);
  assign tab_load_dat[1] = merge_bytes(cont_b, wb_dat_i[15:0], wb_sel_i[1:0]);
  assign tab_addr[0] = ta_s;
  assign tab_addr[1] = ram_mode ? ta_s : tb_s;
  assign tab_wdat = {mpb_s, mpa_s};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tab
      wire [15:0] cont;
      lpsl_table_mem #(
        .DEPTH(`LPSL_TABLE_DEPTH),
        .AW(`LPSL_TABLE_AW)
      ) u_mem (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .load_i(tab_load[gi]),
        .load_dat_i(tab_load_dat[gi]),
        .we_i(ram_mode & ce_s),
        .waddr_i(ta_s),
        .wdat_i(tab_wdat[gi]),
        .raddr_i(tab_addr[gi]),
        .rdat_o(tab_rd[gi]),
        .contents_o(cont)
      );
    end
  endgenerate

  assign cont_a = g_tab[0].cont;
  assign cont_b = g_tab[1].cont;

  // --------------------------------------------------------------
  // ripple arithmetic
  // --------------------------------------------------------------
  wire [1:0] rip_a = counts(op_q) ?
                     registered_out_o : {tb_s[0], ta_s[0]};
  wire [1:0] rip_b = {tb_s[1], ta_s[1]};
  wire [1:0] rip_sum;
  wire rip_cout;
  wire rip_gen;
  wire rip_prop;
  wire rip_ge;
  wire rip_ne;
  wire rip_le;

  lpsl_ripple u_rip (
    .op_i(op_q),
    .a_i(rip_a),
    .b_i(rip_b),
    .cin_i(cin_s),
    .dyn_i(mpa_s),
    .sum_o(rip_sum),
    .cout_o(rip_cout),
    .gen_o(rip_gen),
    .prop_o(rip_prop),
    .ge_o(rip_ge),
    .ne_o(rip_ne),
    .le_o(rip_le)
  );

  // --------------------------------------------------------------
  // slice result selection
  // --------------------------------------------------------------
  reg [1:0] f_d;

  always @* begin
    case (mode_q)
      `LPSL_MODE_RIPPLE: f_d = rip_sum;
      `LPSL_MODE_LOGIC: f_d = tab_rd;
      `LPSL_MODE_RAM: f_d = tab_rd;
      `LPSL_MODE_ROM: f_d = tab_rd;
      default: f_d = tab_rd;
    endcase
  end

  wire ripple_mode = mode_is(mode_q, `LPSL_MODE_RIPPLE);

  // --------------------------------------------------------------
  // table outputs
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      table_bypass_out_o <= 2'h0;
      five_input_mux_out_o <= 1'b0;
    end else begin
      table_bypass_out_o <= f_d;
      five_input_mux_out_o <= mpa_s ? tab_rd[1] : tab_rd[0];
    end
  end

  // --------------------------------------------------------------
  // cascade output
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wide_mux_out_o <= 1'b0;
    end else begin
      wide_mux_out_o <= mpb_s ? wb_s : wa_s;
    end
  end

  // --------------------------------------------------------------
  // carry outputs, zero outside ripple mode
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      carry_chain_out_o <= 1'b0;
      carry_gen_o <= 1'b0;
      carry_prop_o <= 1'b0;
    end else begin
      carry_chain_out_o <= ripple_mode & rip_cout;
      carry_gen_o <= ripple_mode & rip_gen;
      carry_prop_o <= ripple_mode & rip_prop;
    end
  end

  // --------------------------------------------------------------
  // compare outputs, zero outside ripple mode
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      cmp_ge_o <= 1'b0;
      cmp_ne_o <= 1'b0;
      cmp_le_o <= 1'b0;
    end else begin
      cmp_ge_o <= ripple_mode & rip_ge;
      cmp_ne_o <= ripple_mode & rip_ne;
      cmp_le_o <= ripple_mode & rip_le;
    end
  end

  // --------------------------------------------------------------
  // slice registers
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      registered_out_o <= 2'h0;
    end else if (lsr_s) begin
      registered_out_o <= init_q;
    end else if (ce_s) begin
      registered_out_o <= f_d;
    end
  end

  // --------------------------------------------------------------
  // wishbone answer
  // --------------------------------------------------------------
  reg [31:0] rd_d;

  always @* begin
    rd_d = 32'h0;
    if (hit_ctrl) begin
      rd_d[1:0] = mode_q;
      rd_d[4:2] = op_q;
      rd_d[6:5] = init_q;
    end else if (hit_ta) begin
      rd_d[15:0] = cont_a;
    end else if (hit_tb) begin
      rd_d[15:0] = cont_b;
    end else if (hit_st) begin
      rd_d[1:0] = table_bypass_out_o;
      rd_d[3:2] = registered_out_o;
      rd_d[4] = carry_chain_out_o;
      rd_d[5] = carry_gen_o;
      rd_d[6] = carry_prop_o;
      rd_d[7] = cmp_ge_o;
      rd_d[8] = cmp_ne_o;
      rd_d[9] = cmp_le_o;
      rd_d[10] = five_input_mux_out_o;
      rd_d[11] = wide_mux_out_o;
      rd_d[12] = (FULL_UNIT != 0);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // --------------------------------------------------------------
  // read data register, zero outside the ack cycle
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_d : 32'h0;
    end
  end

endmodule

/* rtl/lpsl_table_mem.v */
// Purpose: one 16x1 lookup table store with registered read
// Assumes: single clock, synchronous reset
// Notes: whole-table load beats single-bit write
`timescale 1ns/1ps
`include "lpsl_defines.vh"

module lpsl_table_mem #(
  parameter DEPTH = `LPSL_TABLE_DEPTH,
  parameter AW = `LPSL_TABLE_AW
) (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [DEPTH-1:0] load_dat_i,
  input wire we_i,
  input wire [AW-1:0] waddr_i,
  input wire wdat_i,
  input wire [AW-1:0] raddr_i,
  output reg rdat_o,
  output wire [DEPTH-1:0] contents_o
);

  reg [DEPTH-1:0] mem_q;

  assign contents_o = mem_q;

  // --------------------------------------------------------------
  // storage and read register
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_q <= `LPSL_TABLE_RST;
      rdat_o <= 1'b0;
    end else begin
      if (load_i) begin
        mem_q <= load_dat_i;
      end else if (we_i) begin
        mem_q[waddr_i] <= wdat_i;
      end
      rdat_o <= mem_q[raddr_i];
    end
  end

endmodule

/* verification/lpsl_neighbour.sv */
// Purpose: neighbouring slice driving carry and wide results
// Assumes: shares the slice clock
// Notes: outputs launched from its own flops
`timescale 1ns/1ps
module lpsl_neighbour (
  input wire clk_i,
  input wire [2:0] drive_i,
  output reg carry_o = 1'b0,
  output reg wide_a_o = 1'b0,
  output reg wide_b_o = 1'b0
);
  always @(posedge clk_i) begin
    carry_o <= drive_i[0];
    wide_a_o <= drive_i[1];
    wide_b_o <= drive_i[2];
  end
endmodule

/* verification/lpsl_slice_monitor.sv */
// Purpose: port checker of the logic slice
// Assumes: one clock domain, synchronous reset
// Notes: bound to every slice instance
`timescale 1ns/1ps
module lpsl_slice_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire multipurpose_in_b_i,
  input wire clk_en_i,
  input wire local_set_reset_i,
  input wire wide_in_a_i,
  input wire wide_in_b_i,
  input wire [1:0] registered_out_o,
  input wire wide_mux_out_o,
  input wire cmp_ge_o,
  input wire cmp_ne_o,
  input wire cmp_le_o
);
  // ----
  // cycles since reset
  // ----
  reg [2:0] up_q;
  always @(posedge clk_i) begin
    if (rst_i) up_q <= 3'h0;
    else if (up_q != 3'h7) up_q <= up_q + 3'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("ack without request");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  AST_LSR_HOLD: assert property (up_q == 3'h7 && $past(local_set_reset_i, 3) &&
    $past(local_set_reset_i, 4) && !$past(wb_ack_o) && !$past(wb_ack_o, 2)
    |-> $stable(registered_out_o)) else $error("register moved under set/reset");
  AST_CE_HOLD: assert property (up_q == 3'h7 && !$past(clk_en_i, 3) &&
    !$past(clk_en_i, 4) && !$past(local_set_reset_i, 3) && !$past(local_set_reset_i, 4)
    |-> $stable(registered_out_o)) else $error("register moved without enable");
  AST_WIDE_MUX: assert property (up_q == 3'h7 |-> wide_mux_out_o ==
    ($past(multipurpose_in_b_i, 3) ? $past(wide_in_b_i, 3) : $past(wide_in_a_i, 3)))
    else $error("wide mux output wrong");
  AST_CMP_NE: assert property (cmp_ne_o |-> !(cmp_ge_o && cmp_le_o))
    else $error("not-equal with ge and le");
  AST_CMP_EQ: assert property (cmp_ge_o && !cmp_ne_o |-> cmp_le_o)
    else $error("equal without le");
endmodule
bind lpsl_slice lpsl_slice_monitor lpsl_slice_monitor_inst (.*);

/* verification/lpsl_slice_tb.sv */
// Purpose: self-checking bench of the logic slice
// Assumes: 10 MHz clock, bus answer after one cycle
// Notes: random stimulus from a 16-bit shift register
`timescale 1ns/1ps
`include "lpsl_defines.vh"
module lpsl_slice_tb;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg wb_cyc_i = 1'b0;
  reg wb_stb_i = 1'b0;
  reg wb_we_i = 1'b0;
  reg [4:0] wb_adr_i = 5'h00;
  reg [3:0] wb_sel_i = 4'h0;
  reg [31:0] wb_dat_i = 32'h0;
  reg [3:0] table_a_inputs_i = 4'h0;
  reg [3:0] table_b_inputs_i = 4'h0;
  reg multipurpose_in_a_i = 1'b0;
  reg multipurpose_in_b_i = 1'b0;
  reg clk_en_i = 1'b0;
  reg local_set_reset_i = 1'b0;
  reg [2:0] nb = 3'h0;
  wire carry_chain_in_i, wide_in_a_i, wide_in_b_i, wb_ack_o, ack2;
  wire [31:0] wb_dat_o, dat2;
  wire five_input_mux_out_o, wide_mux_out_o, carry_chain_out_o, carry_gen_o, carry_prop_o;
  wire cmp_ge_o, cmp_ne_o, cmp_le_o;
  wire [1:0] table_bypass_out_o, registered_out_o;
  reg [15:0] rnd = 16'hee1a;
  reg [31:0] rd, rd2;
  reg [15:0] ta, tb;
  reg [1:0] qx;
  integer n_mismatch = 0;
  integer check_count = 0;
  integer m;
  lpsl_neighbour lpsl_neighbour_inst (.clk_i(clk_i), .drive_i(nb),
    .carry_o(carry_chain_in_i), .wide_a_o(wide_in_a_i), .wide_b_o(wide_in_b_i));
  lpsl_slice lpsl_slice_inst (.*);
  lpsl_slice #(.FULL_UNIT(0)) lpsl_slice_reduced_inst (.*, .wb_dat_o(dat2), .wb_ack_o(ack2),
    .table_bypass_out_o(), .registered_out_o(), .five_input_mux_out_o(), .wide_mux_out_o(),
    .carry_chain_out_o(), .carry_gen_o(), .carry_prop_o(), .cmp_ge_o(), .cmp_ne_o(),
    .cmp_le_o());
  initial begin
    forever #50 clk_i = ~clk_i;
  end
  // ----
  // helpers
  // ----
  function [15:0] nx(input [15:0] s);
    nx = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [4:0] rip(input [2:0] op, input [1:0] a, input [1:0] b, input ci, input md);
    reg [1:0] e;
    reg [2:0] s;
    begin
      e = (op == `LPSL_OP_SUB || op == `LPSL_OP_CMP || (op == `LPSL_OP_ADDSUB && md)) ? ~b :
        (op == `LPSL_OP_MULT ? (b & {2{md}}) : b);
      s = a + e + ci;
      rip = {s, a + e > 3, a + e == 3};
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task end_of_test;
    begin
      $display("mismatches %0d checks %0d", n_mismatch, check_count);
      if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task wb(input w, input [4:0] a, input [31:0] d);
    integer i;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      i = 0;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && i < 8) begin
        @(posedge clk_i);
        i = i + 1;
      end
      rd = wb_dat_o;
      rd2 = dat2;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
        n_mismatch = n_mismatch + 1;
        end_of_test;
      end
    end
  endtask
  task settle;
    repeat (7) @(posedge clk_i);
  endtask
  task lut(input [1:0] md);
    integer k;
    reg l;
    reg [1:0] iv;
    begin
      ta = rnd;
      tb = nx(rnd);
      rnd = nx(tb);
      iv = rnd[1:0];
      wb(1'b1, `LPSL_ADR_TABLE_A, {16'h0, ta});
      wb(1'b1, `LPSL_ADR_TABLE_B, {16'h0, tb});
      wb(1'b1, `LPSL_ADR_CTRL, {25'h0, rnd[1:0], 3'h0, md});
      wb(1'b0, `LPSL_ADR_TABLE_A, 32'h0);
      chk(rd, {16'h0, ta});
      for (k = 0; k < 12; k = k + 1) begin
        l = (k == 0) | (rnd[10] & rnd[11]);
        qx = l ? iv : rnd[9] ? {tb[rnd[7:4]], ta[rnd[3:0]]} : qx;
        table_a_inputs_i <= rnd[3:0];
        table_b_inputs_i <= rnd[7:4];
        multipurpose_in_a_i <= rnd[8];
        clk_en_i <= rnd[9];
        local_set_reset_i <= l;
        nb <= rnd[14:12];
        multipurpose_in_b_i <= rnd[15];
        settle;
        chk(table_bypass_out_o, {tb[rnd[7:4]], ta[rnd[3:0]]});
        chk(five_input_mux_out_o, rnd[8] ? tb[rnd[7:4]] : ta[rnd[3:0]]);
        chk(registered_out_o, qx);
        chk(wide_mux_out_o, rnd[15] ? rnd[14] : rnd[13]);
        rnd = nx(rnd);
      end
    end
  endtask
  task ripple(input [2:0] op);
    integer k;
    reg [15:0] v;
    reg [4:0] e;
    begin
      wb(1'b1, `LPSL_ADR_CTRL, {27'h0, op, `LPSL_MODE_RIPPLE});
      for (k = 0; k < 10; k = k + 1) begin
        rnd = nx(rnd);
        v = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : rnd;
        table_a_inputs_i <= {v[7:6], v[1:0]};
        table_b_inputs_i <= v[3:0] >> 2;
        nb <= v[6:4];
        multipurpose_in_a_i <= v[5];
        e = rip(op, {v[2], v[0]}, {v[3], v[1]}, v[4], v[5]);
        settle;
        chk(table_bypass_out_o, e[3:2]);
        if (op != `LPSL_OP_CMP) chk({carry_chain_out_o, carry_gen_o, carry_prop_o},
          {e[4], e[1:0]});
        else chk({cmp_ge_o, cmp_ne_o, cmp_le_o}, {v[3:0] >= 4'h0 && {v[2], v[0]} >=
          {v[3], v[1]}, {v[2], v[0]} != {v[3], v[1]}, {v[2], v[0]} <= {v[3], v[1]}});
      end
    end
  endtask
  task count(input [2:0] op);
    reg [1:0] q;
    reg [1:0] s;
    reg [3:0] n;
    begin
      rnd = nx(rnd);
      q = rnd[1:0];
      n = {1'b0, rnd[4:2]} + 4'h1;
      clk_en_i <= 1'b0;
      local_set_reset_i <= 1'b1;
      nb <= 3'h1;
      wb(1'b1, `LPSL_ADR_CTRL, {25'h0, q, op, `LPSL_MODE_RIPPLE});
      settle;
      chk(registered_out_o, q);
      local_set_reset_i <= 1'b0;
      clk_en_i <= 1'b1;
      repeat (n) @(posedge clk_i);
      clk_en_i <= 1'b0;
      q = (op == `LPSL_OP_UP) ? q + n[1:0] : q - n[1:0];
      s = (op == `LPSL_OP_UP) ? q + 2'h1 : q - 2'h1;
      settle;
      chk(registered_out_o, q);
      chk(table_bypass_out_o, s);
    end
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `LPSL_ADR_CTRL, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 5'h10, 32'hffffffff);
    chk(rd, 32'h0);
    wb(1'b0, `LPSL_ADR_TABLE_B, 32'h0);
    chk(rd, 32'h0);
    lut(`LPSL_MODE_LOGIC);
    lut(`LPSL_MODE_ROM);
    for (m = 0; m < 7; m = m + 1) begin
      if (m != 3 && m != 4) ripple(m[2:0]);
      else count(m[2:0]);
    end
    wb(1'b1, `LPSL_ADR_CTRL, {30'h0, `LPSL_MODE_RAM});
    wb(1'b0, `LPSL_ADR_CTRL, 32'h0);
    chk({rd[1:0], rd2[1:0]}, {`LPSL_MODE_RAM, `LPSL_MODE_RIPPLE});
    for (m = 0; m < 6; m = m + 1) begin
      rnd = nx(rnd);
      table_a_inputs_i <= rnd[3:0];
      multipurpose_in_a_i <= rnd[4];
      multipurpose_in_b_i <= rnd[5];
      clk_en_i <= 1'b1;
      ta[rnd[3:0]] = rnd[4];
      tb[rnd[3:0]] = rnd[5];
      settle;
    end
    clk_en_i <= 1'b0;
    settle;
    wb(1'b0, `LPSL_ADR_TABLE_A, 32'h0);
    chk(rd, {16'h0, ta});
    wb(1'b0, `LPSL_ADR_TABLE_B, 32'h0);
    chk(rd, {16'h0, tb});
    end_of_test;
  end
endmodule
